//--- testbench/chgc_host_model.sv
`timescale 1ns/1ps
// Host side: pulled-up open-drain lines, source detector, strap
module chgc_host_model
  import chgc_pkg::*;
(
  input wire logic usb_host,
  input wire logic allow,
  input wire logic status_oe,
  input wire logic alert_oe,
  input wire logic pg_oe,
  output logic source_select,
  output logic charge_allow_n,
  output logic status_w,
  output logic alert_w,
  output logic pg_w
);
  assign source_select = usb_host;
  assign charge_allow_n = !allow;
  assign status_w = !status_oe;
  assign alert_w = !alert_oe;
  assign pg_w = !pg_oe;
endmodule : chgc_host_model

//--- testbench/chgc_top_sva.sv
`timescale 1ns/1ps
module chgc_top_chk
  import chgc_pkg::*;
#(
  parameter int unsigned SHIP_CYCLES = SHIP_EXIT_CYCLES,
  parameter int unsigned ALERT_CYCLES = ALERT_PULSE_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic source_select,
  input wire logic boost_request,
  input wire logic charge_allow_n,
  input wire logic [2:0] input_limit_resistor,
  input wire logic ship_exit_in,
  input wire chgc_sense_t sense,
  input wire logic alert_oe,
  input wire logic power_good_n_oe,
  input wire chgc_ctrl_t ctrl
);
  int unsigned acnt;
  int unsigned hcnt;
  logic off;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Alert length, ship pin high time, battery switch turned off
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      acnt <= 0;
      hcnt <= 0;
      off <= 1'b0;
    end
    else
    begin
      acnt <= alert_oe ? acnt + 1 : 0;
      hcnt <= ship_exit_in ? hcnt + 1 : 0;
      off <= $fell(ctrl.battery_switch) || (off && !ctrl.battery_switch);
    end
  chk_alert_start: assert property ($rose(sense.fault) && !alert_oe |=> alert_oe)
    else $error("alert not started");
  chk_alert_len: assert property ($fell(alert_oe) |-> acnt == ALERT_CYCLES)
    else $error("alert length off");
  chk_boost_gate: assert property (ctrl.boost_enable |-> $past(boost_request))
    else $error("boost without request");
  chk_charge_gate: assert property (ctrl.charge_enable |-> !$past(charge_allow_n))
    else $error("charge without allow");
  chk_usb_low: assert property (source_select && !boost_request
    ##1 source_select && !boost_request |-> ctrl.input_current == INPUT_LIMIT_RESISTOR_100MA)
    else $error("usb low limit");
  chk_usb_high: assert property (source_select ##1 source_select
    |-> ctrl.input_current <= INPUT_LIMIT_RESISTOR_500MA)
    else $error("usb high limit");
  chk_res_min: assert property (input_limit_resistor >= 3'h2
    ##1 $stable(input_limit_resistor) |-> ctrl.input_current <= input_limit_resistor)
    else $error("resistor limit exceeded");
  chk_pg_window: assert property (power_good_n_oe |-> $past(sense.vin_above_uvlo
    && sense.vin_below_acov && sense.vin_above_sleep))
    else $error("power good outside window");
  chk_ts_boost: assert property (!sense.ts_in_window ##1 !sense.ts_in_window
    |-> !ctrl.boost_enable)
    else $error("boost with cold or hot battery");
  chk_supp_order: assert property ($rose(ctrl.supplement) |-> $past(ctrl.charge_suspend))
    else $error("supplement before suspend");
  chk_therm_red: assert property (sense.tj_above_reg ##1 sense.tj_above_reg
    |-> ctrl.charge_reduce)
    else $error("no thermal reduction");
  chk_ship_exit: assert property ($rose(ctrl.battery_switch) && off
    |-> hcnt >= SHIP_CYCLES)
    else $error("ship exit too early");
  cover property ($rose(alert_oe));
  cover property ($rose(ctrl.boost_enable));
  cover property ($rose(ctrl.supplement));
endmodule : chgc_top_chk
bind chgc_top chgc_top_chk #(.SHIP_CYCLES(SHIP_CYCLES), .ALERT_CYCLES(ALERT_CYCLES)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .source_select(source_select),
  .boost_request(boost_request), .charge_allow_n(charge_allow_n),
  .input_limit_resistor(input_limit_resistor), .ship_exit_in(ship_exit_in),
  .sense(sense), .alert_oe(alert_oe), .power_good_n_oe(power_good_n_oe), .ctrl(ctrl));

//--- testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import chgc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  chgc_bus_req_t bus_req = '0;
  logic [7:0] bus_rdata;
  logic usb_host = 1'b1;
  logic allow = 1'b1;
  logic boost_request = 1'b0;
  logic [2:0] input_limit_resistor = 3'h2;
  logic ship_exit_in = 1'b0;
  // Input in window, thermistor in window
  chgc_sense_t sense = 11'h708;
  logic status_o, status_oe, alert_o, alert_oe, pg_o, pg_oe;
  logic source_select, charge_allow_n, status_w, alert_w, pg_w;
  chgc_ctrl_t ctrl;
  int n_errors = 0;
  int samples_checked = 0;
  logic [7:0] rv;
  initial forever #4 ref_clk = ~ref_clk;
  chgc_top #(.SHIP_CYCLES(20), .BLINK_CYCLES(8), .ALERT_CYCLES(256)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .source_select(source_select), .boost_request(boost_request),
    .charge_allow_n(charge_allow_n), .input_limit_resistor(input_limit_resistor),
    .ship_exit_in(ship_exit_in), .sense(sense), .status_o(status_o),
    .status_oe(status_oe), .alert_o(alert_o), .alert_oe(alert_oe),
    .power_good_n_o(pg_o), .power_good_n_oe(pg_oe), .ctrl(ctrl));
  chgc_host_model hm (.usb_host(usb_host), .allow(allow), .status_oe(status_oe),
    .alert_oe(alert_oe), .pg_oe(pg_oe), .source_select(source_select),
    .charge_allow_n(charge_allow_n), .status_w(status_w), .alert_w(alert_w), .pg_w(pg_w));
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk) bus_req <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk) bus_req <= '0;
    #1 rv = bus_rdata;
  endtask : rd
  task automatic ph(input logic [2:0] e);
    rd(ADDR_STATUS);
    for (int i = 0; i < 8 && rv[6:4] !== e; i++)
      rd(ADDR_STATUS);
    chk("phase", 8'(e), 8'(rv[6:4]));
  endtask : ph
  task automatic t_regs();
    rd(ADDR_INPUT_SOURCE);
    chk("in_src", IN_SRC_RST, rv);
    rd(ADDR_POWER_CONFIG);
    chk("pwr_cfg", PWR_CFG_RST, rv);
    rd(ADDR_THERMAL);
    chk("therm", THERM_REG_RST, rv);
    cyc(1);
    chk("rd_idle", 8'h00, bus_rdata);
    chk("od_level", 8'h00, 8'({status_o, alert_o, pg_o}));
    wr(4'hA, 8'h55);
    rd(4'hA);
    chk("unmapped", 8'h00, rv);
  endtask : t_regs
  task automatic t_charge();
    ph(CHGC_PRECOND);
    chk("stat_chg", 8'h00, 8'(status_w));
    chk("chg_en", 8'h01, 8'(ctrl.charge_enable));
    @(posedge ref_clk) sense.vbat_above_precond <= 1'b1;
    ph(CHGC_CC);
    @(posedge ref_clk) sense.vbat_at_regulation <= 1'b1;
    ph(CHGC_CV);
    @(posedge ref_clk) sense.ichg_below_term <= 1'b1;
    ph(CHGC_DONE);
    cyc(2);
    chk("stat_done", 8'h01, 8'(status_w));
    @(posedge ref_clk) sense[6:4] <= 3'b001;
    ph(CHGC_CC);
    @(posedge ref_clk) allow <= 1'b0;
    cyc(3);
    chk("chg_off", 8'h00, 8'(ctrl.charge_enable));
    chk("stat_off", 8'h01, 8'(status_w));
    @(posedge ref_clk) allow <= 1'b1;
    sense.vbat_below_recharge <= 1'b0;
    cyc(300);
  endtask : t_charge
  task automatic t_fault();
    int n = 0;
    int tg = 0;
    logic s;
    @(posedge ref_clk) sense.fault <= 1'b1;
    cyc(1);
    s = status_w;
    while (alert_w === 1'b0 && n < 400)
    begin
      cyc(1);
      n++;
      tg += (status_w !== s);
      s = status_w;
    end
    chk("alert_len", 8'h01, 8'(n == ALERT_PULSE_CYCLES));
    chk("blink", 8'h01, 8'(tg > 20));
    @(posedge ref_clk) sense.fault <= 1'b0;
    cyc(4);
    chk("stat_steady", 8'h00, 8'(status_w));
  endtask : t_fault
  task automatic t_limit();
    cyc(3);
    chk("usb_100", 8'(INPUT_LIMIT_RESISTOR_100MA), 8'(ctrl.input_current));
    @(posedge ref_clk) boost_request <= 1'b1;
    cyc(3);
    chk("usb_500", 8'(INPUT_LIMIT_RESISTOR_500MA), 8'(ctrl.input_current));
    chk("no_boost", 8'h00, 8'(ctrl.boost_enable));
    wr(ADDR_POWER_CONFIG, 8'h2B);
    cyc(3);
    chk("boost", 8'h01, 8'(ctrl.boost_enable));
    @(posedge ref_clk) sense.ts_in_window <= 1'b0;
    cyc(3);
    chk("ts_boost", 8'h00, 8'(ctrl.boost_enable));
    @(posedge ref_clk) sense.ts_in_window <= 1'b1;
    boost_request <= 1'b0;
    usb_host <= 1'b0;
    input_limit_resistor <= 3'h4;
    wr(ADDR_POWER_CONFIG, PWR_CFG_RST);
    wr(ADDR_INPUT_SOURCE, 8'h07);
    cyc(3);
    chk("res_min", 8'h04, 8'(ctrl.input_current));
    wr(ADDR_INPUT_SOURCE, 8'h03);
    @(posedge ref_clk) input_limit_resistor <= 3'h7;
    cyc(3);
    chk("reg_min", 8'h03, 8'(ctrl.input_current));
    wr(ADDR_INPUT_SOURCE, IN_SRC_RST);
  endtask : t_limit
  task automatic t_misc();
    @(posedge ref_clk) sense.vin_above_sleep <= 1'b0;
    cyc(3);
    chk("pg_sleep", 8'h01, 8'(pg_w));
    @(posedge ref_clk) sense.vin_above_sleep <= 1'b1;
    sense.in_limit_reached <= 1'b1;
    sense.tj_above_reg <= 1'b1;
    cyc(4);
    chk("pg_good", 8'h00, 8'(pg_w));
    chk("suspend", 8'h03, 8'({ctrl.charge_suspend, ctrl.supplement}));
    chk("reduce", 8'h01, 8'(ctrl.charge_reduce));
    @(posedge ref_clk) sense[2:1] <= 2'b00;
    wr(ADDR_STATUS, 8'h01);
    cyc(3);
    chk("ship_on", 8'h00, 8'(ctrl.battery_switch));
    @(posedge ref_clk) ship_exit_in <= 1'b1;
    cyc(10);
    @(posedge ref_clk) ship_exit_in <= 1'b0;
    cyc(4);
    chk("ship_short", 8'h00, 8'(ctrl.battery_switch));
    @(posedge ref_clk) ship_exit_in <= 1'b1;
    cyc(30);
    chk("ship_exit", 8'h01, 8'(ctrl.battery_switch));
  endtask : t_misc
  initial
  begin
    #(8 * 20000);
    n_errors++;
    test_done();
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_charge();
    t_fault();
    t_limit();
    t_misc();
    test_done();
  end
endmodule : tb_top

//--- verilog/chgc_phase_seq.sv
`timescale 1ns/1ps
// Autonomous charge phase sequencer
module chgc_phase_seq
  import chgc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire chgc_sense_t sense,
  output chgc_phase_t phase,
  output logic terminated
);
  typedef struct packed {
    chgc_phase_t phase;
    logic term;
  } chgc_seq_st_t;

  chgc_seq_st_t s_q;
  chgc_seq_st_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.term = 1'b0;
    if (!enable)
    begin
      s_d.phase = CHGC_IDLE;
    end
    else
    begin
      case (s_q.phase)
        CHGC_IDLE: s_d.phase = CHGC_PRECOND;
        CHGC_PRECOND:
        begin
          if (sense.vbat_above_precond)
          begin
            s_d.phase = CHGC_CC;
          end
        end
        CHGC_CC:
        begin
          if (sense.vbat_at_regulation)
          begin
            s_d.phase = CHGC_CV;
          end
        end
        CHGC_CV:
        begin
          if (sense.ichg_below_term)
          begin
            s_d.phase = CHGC_DONE;
            s_d.term = 1'b1;
          end
        end
        CHGC_DONE:
        begin
          if (sense.vbat_below_recharge)
          begin
            s_d.phase = CHGC_PRECOND;
          end
        end
        default: s_d.phase = CHGC_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '{phase: CHGC_IDLE, term: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign phase = s_q.phase;
  assign terminated = s_q.term;

endmodule : chgc_phase_seq

//--- verilog/chgc_pkg.sv
package chgc_pkg;

  // Clock and timing
  localparam int unsigned CLK_FREQ_HZ = 125_000_000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  // Alert pulse length in clock cycles
  localparam int unsigned ALERT_PULSE_CYCLES = 256;
  // Ship exit qualification: 2 ms minimum high
  localparam int unsigned SHIP_EXIT_MS = 2;
  localparam int unsigned SHIP_EXIT_CYCLES = (SHIP_EXIT_MS * 1_000_000 + CLK_PERIOD_NS - 1)
                                             / CLK_PERIOD_NS;
  // Fault blink: 1 Hz, half period per level
  localparam int unsigned BLINK_HZ = 1;
  localparam int unsigned BLINK_HALF_CYCLES = CLK_FREQ_HZ / (2 * BLINK_HZ);

  // Register field positions
  localparam int unsigned CFG_BOOST_BIT = 5;
  localparam int unsigned CFG_CHG_LSB = 4;
  localparam logic [1:0] CFG_CHG_ENABLE = 2'h1;
  localparam logic [7:0] PWR_CFG_RST = 8'h1B;
  localparam logic [7:0] IN_SRC_RST = 8'h02;

  // Register offsets
  localparam logic [3:0] ADDR_INPUT_SOURCE = 4'h0;
  localparam logic [3:0] ADDR_POWER_CONFIG = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_THERMAL = 4'h3;

  // Input current limit codes (bits 2:0)
  localparam logic [2:0] INPUT_LIMIT_RESISTOR_100MA = 3'h0;
  localparam logic [2:0] INPUT_LIMIT_RESISTOR_500MA = 3'h2;
  localparam logic [2:0] INPUT_LIMIT_RESISTOR_30MA_ABOVE = 3'h0;
  localparam logic [7:0] THERM_REG_RST = 8'h03;

  typedef enum logic [2:0] {
    CHGC_IDLE = 3'h0,
    CHGC_PRECOND = 3'h1,
    CHGC_CC = 3'h3,
    CHGC_CV = 3'h2,
    CHGC_DONE = 3'h6
  } chgc_phase_t;

  // Analog comparator results
  typedef struct packed {
    logic vin_above_uvlo;
    logic vin_below_acov;
    logic vin_above_sleep;
    logic vbat_above_precond;
    logic vbat_at_regulation;
    logic ichg_below_term;
    logic vbat_below_recharge;
    logic ts_in_window;
    logic tj_above_reg;
    logic in_limit_reached;
    logic fault;
  } chgc_sense_t;

  // Controls toward the power stage
  typedef struct packed {
    logic charge_enable;
    logic boost_enable;
    logic charge_suspend;
    logic charge_reduce;
    logic supplement;
    logic battery_switch;
    logic [2:0] input_current;
  } chgc_ctrl_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } chgc_bus_req_t;

endpackage : chgc_pkg

//--- verilog/chgc_pulse_timer.sv
`timescale 1ns/1ps
// Counts a fixed number of cycles once started; busy while counting
module chgc_pulse_timer
  import chgc_pkg::*;
#(
  parameter int unsigned CYCLES = 256
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic hold,
  output logic busy,
  output logic done
);
  localparam int unsigned CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic busy;
    logic done;
  } chgc_tmr_st_t;

  chgc_tmr_st_t s_q;
  chgc_tmr_st_t s_d;

  initial
  begin
    if (CYCLES < 1)
    begin
      $error("CYCLES must be at least one");
    end
  end

  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (!hold)
    begin
      s_d.busy = 1'b0;
      s_d.cnt = '0;
    end
    else if (start && !s_q.busy)
    begin
      s_d.busy = 1'b1;
      s_d.cnt = CW'(CYCLES - 1);
    end
    else if (s_q.busy)
    begin
      if (s_q.cnt == '0)
      begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
      else
      begin
        s_d.cnt = s_q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;
  assign done = s_q.done;

endmodule : chgc_pulse_timer

//--- verilog/chgc_top.sv
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module chgc_top
  import chgc_pkg::*;
#(
  parameter int unsigned SHIP_CYCLES = SHIP_EXIT_CYCLES,
  parameter int unsigned BLINK_CYCLES = BLINK_HALF_CYCLES,
  parameter int unsigned ALERT_CYCLES = ALERT_PULSE_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire chgc_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire logic source_select,
  input wire logic boost_request,
  input wire logic charge_allow_n,
  input wire logic [2:0] input_limit_resistor,
  input wire logic ship_exit_in,
  input wire chgc_sense_t sense,
  output logic status_o,
  output logic status_oe,
  output logic alert_o,
  output logic alert_oe,
  output logic power_good_n_o,
  output logic power_good_n_oe,
  output chgc_ctrl_t ctrl
);
  initial
  begin
    if (SHIP_CYCLES < 1 || BLINK_CYCLES < 1)
    begin
      $error("Timing counts must be at least one");
    end
    // Alert timer covers all but the first pulse cycle
    if (ALERT_CYCLES < 2)
    begin
      $error("Alert pulse must last at least two cycles");
    end
  end

  localparam int unsigned BW = $clog2(BLINK_CYCLES + 1);

  typedef struct packed {
    logic [7:0] input_source_reg;
    logic [7:0] power_config_reg;
    logic [7:0] thermal_reg;
    logic [7:0] rdata;
    logic [BW-1:0] blink_cnt;
    logic blink_lvl;
    logic fault_seen;
    logic ship_prev;
    logic shipping;
    logic status_oe;
    logic alert_oe;
    logic pg_oe;
    chgc_ctrl_t ctrl;
  } chgc_top_st_t;

  chgc_top_st_t s_q;
  chgc_top_st_t s_d;

  chgc_phase_t phase;
  logic terminated;
  logic alert_busy;
  logic ship_done;
  logic ship_busy;
  logic charge_en;
  logic boost_en;
  logic [2:0] reg_limit;
  logic [2:0] pin_limit;
  logic [2:0] eff_limit;
  logic fault_rise;
  logic alert_evt;
  logic ship_rise;
  logic buck_usb;
  logic [2:0] usb_default;
  logic charging;
  logic status_pull;
  logic [7:0] status_word;
  logic [7:0] rd_word;
  logic [2:0] od_oe;
  logic [2:0] od_level;

  // Charge allowed and boost allowed decisions
  assign charge_en = (s_q.power_config_reg[CFG_CHG_LSB +: 2] == CFG_CHG_ENABLE)
                     && !charge_allow_n;
  assign boost_en = s_q.power_config_reg[CFG_BOOST_BIT] && boost_request;

  // Buck mode with a USB host port behind the input
  assign buck_usb = !boost_en && source_select;

  // USB default limit follows the boost request pin in buck mode
  always_comb
  begin
    if (boost_request)
    begin
      usb_default = INPUT_LIMIT_RESISTOR_500MA;
    end
    else
    begin
      usb_default = INPUT_LIMIT_RESISTOR_100MA;
    end
  end

  // Register limit, clamped to the USB default when that applies
  always_comb
  begin
    reg_limit = s_q.input_source_reg[2:0];
    if (buck_usb && (usb_default < reg_limit))
    begin
      reg_limit = usb_default;
    end
  end

  // Resistor pin never sets less than 500 mA
  assign pin_limit = (input_limit_resistor < INPUT_LIMIT_RESISTOR_500MA) ? INPUT_LIMIT_RESISTOR_500MA
                     : input_limit_resistor;
  assign eff_limit = (pin_limit < reg_limit) ? pin_limit : reg_limit;
  assign fault_rise = sense.fault && !s_q.fault_seen;
  // Events that raise the alert; refused while a pulse is out
  assign alert_evt = (fault_rise || terminated) && !s_q.alert_oe;
  assign ship_rise = ship_exit_in && !s_q.ship_prev;

  // Phases run only while charging is allowed and not shipping
  chgc_phase_seq u_seq (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .enable(charge_en && !s_q.shipping),
    .sense(sense),
    .phase(phase),
    .terminated(terminated)
  );

  // First pulse cycle comes from the event itself
  chgc_pulse_timer #(
    .CYCLES(ALERT_CYCLES - 1)
  ) u_alert (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(alert_evt),
    .hold(1'b1),
    .busy(alert_busy),
    .done()
  );

  // Qualifies the high level that follows a rising edge
  chgc_pulse_timer #(
    .CYCLES(SHIP_CYCLES)
  ) u_ship (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(ship_rise),
    .hold(ship_exit_in),
    .busy(ship_busy),
    .done(ship_done)
  );

  // Live status word seen by a read of the status register
  assign status_word = {sense.fault, phase, terminated, boost_en, charge_en, s_q.shipping};

  // Read multiplexer; unmapped offsets read as zero
  always_comb
  begin
    case (bus_req.addr)
      ADDR_INPUT_SOURCE:
      begin
        rd_word = s_q.input_source_reg;
      end
      ADDR_POWER_CONFIG:
      begin
        rd_word = s_q.power_config_reg;
      end
      ADDR_STATUS:
      begin
        rd_word = status_word;
      end
      ADDR_THERMAL:
      begin
        rd_word = s_q.thermal_reg;
      end
      default:
      begin
        rd_word = 8'h00;
      end
    endcase
  end

  // Charging phases pull the status line low
  always_comb
  begin
    case (phase)
      CHGC_PRECOND:
      begin
        charging = 1'b1;
      end
      CHGC_CC:
      begin
        charging = 1'b1;
      end
      CHGC_CV:
      begin
        charging = 1'b1;
      end
      default:
      begin
        charging = 1'b0;
      end
    endcase
  end
  assign status_pull = charge_en && charging;

  always_comb
  begin
    s_d = s_q;
    s_d.fault_seen = sense.fault;
    s_d.ship_prev = ship_exit_in;
    s_d.rdata = 8'h00;

    // Register writes; unmapped offsets are ignored
    if (bus_req.wr)
    begin
      case (bus_req.addr)
        ADDR_INPUT_SOURCE:
        begin
          s_d.input_source_reg = bus_req.wdata;
        end
        ADDR_POWER_CONFIG:
        begin
          s_d.power_config_reg = bus_req.wdata;
        end
        ADDR_THERMAL:
        begin
          s_d.thermal_reg = bus_req.wdata;
        end
        ADDR_STATUS:
        begin
          s_d.shipping = bus_req.wdata[0];
        end
        default:
        begin
          s_d.rdata = 8'h00;
        end
      endcase
    end
    // Read data stands for one cycle only
    if (bus_req.rd)
    begin
      s_d.rdata = rd_word;
    end

    if (ship_done)
    begin
      s_d.shipping = 1'b0;
    end

    // Blink timebase runs only while a fault is present
    if (!sense.fault)
    begin
      s_d.blink_cnt = '0;
      s_d.blink_lvl = 1'b0;
    end
    else if (s_q.blink_cnt == BW'(BLINK_CYCLES - 1))
    begin
      s_d.blink_cnt = '0;
      s_d.blink_lvl = !s_q.blink_lvl;
    end
    else
    begin
      s_d.blink_cnt = s_q.blink_cnt + 1'b1;
    end

    if (sense.fault)
    begin
      s_d.status_oe = !s_d.blink_lvl;
    end
    else
    begin
      s_d.status_oe = status_pull;
    end

    // Alert pulse: event cycle, then the timer's remaining cycles
    s_d.alert_oe = alert_busy || alert_evt;
    s_d.pg_oe = sense.vin_above_uvlo && sense.vin_below_acov
                && sense.vin_above_sleep && (eff_limit > INPUT_LIMIT_RESISTOR_30MA_ABOVE);

    // Charging needs the allow decision, no shipping and no boost
    s_d.ctrl.charge_enable = charge_en && !s_q.shipping && !boost_en;
    // Boost output is dropped with the thermistor out of window
    s_d.ctrl.boost_enable = boost_en && sense.ts_in_window;
    s_d.ctrl.charge_suspend = !sense.ts_in_window || sense.in_limit_reached;
    s_d.ctrl.charge_reduce = sense.tj_above_reg;
    // Supplement only once charge current has been cut
    s_d.ctrl.supplement = sense.in_limit_reached && s_q.ctrl.charge_suspend;
    s_d.ctrl.battery_switch = !s_d.shipping;
    s_d.ctrl.input_current = eff_limit;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.input_source_reg <= IN_SRC_RST;
      s_q.power_config_reg <= PWR_CFG_RST;
      s_q.thermal_reg <= THERM_REG_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign bus_rdata = s_q.rdata;
  // Open-drain pins: level is always low, the enable pulls the line
  assign od_oe = {s_q.status_oe, s_q.alert_oe, s_q.pg_oe};
  for (genvar i = 0; i < 3; i++)
  begin : g_od
    assign od_level[i] = 1'b0;
  end
  assign status_o = od_level[2];
  assign status_oe = od_oe[2];
  assign alert_o = od_level[1];
  assign alert_oe = od_oe[1];
  assign power_good_n_o = od_level[0];
  assign power_good_n_oe = od_oe[0];
  assign ctrl = s_q.ctrl;

endmodule : chgc_top
